// *** common/pao_regs.svh ***
/*
  Constants for the pipelined converter output port: word width, pipeline depth, code points, recovery time.
  Assumes the including file runs at 40 MHz on clk_sys.
*/
`ifndef PAO_REGS_SVH
`define PAO_REGS_SVH
`define PAO_WORD_W 12
`define PAO_PIPE_DEPTH 6
`define PAO_CODE_MIN 12'h000
`define PAO_CODE_MID 12'h800
`define PAO_CODE_MAX 12'hfff
`define PAO_CLK_PERIOD_NS 25
`define PAO_RECOVER_NS 500
`define PAO_RECOVER_CYC ((`PAO_RECOVER_NS + `PAO_CLK_PERIOD_NS - 1) / `PAO_CLK_PERIOD_NS)
`endif

// *** common/pao_pkg.sv ***
/*
  Types for the pipelined converter output port.
  Assumes pao_regs.svh is available on the include path.
*/
`include "pao_regs.svh"
package pao_pkg;
  typedef logic [`PAO_WORD_W-1:0] pao_word_t;
  typedef logic signed [`PAO_WORD_W+1:0] pao_diff_t;
  typedef enum logic [1:0] {
    PAO_RUN,
    PAO_SLEEP,
    PAO_WAKE
  } pao_mode_e;
endpackage : pao_pkg

// *** src/pao_delay_line.sv ***
/*
  Fixed-depth word delay line; every stage advances each clock.
  Assumes a synchronous active-high flush that zeroes all stages.
*/
`timescale 1ns/10ps
module pao_delay_line #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 6
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } pao_dl_s;
  pao_dl_s st_q;
  pao_dl_s st_d;

  // Shift every stage by one each cycle
  always_comb begin
    st_d = st_q;
    st_d.stage[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      st_d.stage[i] = st_q.stage[i-1];
    end
    if (flush) begin
      st_d = '0;
    end
  end

  // Register the line
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.stage[DEPTH-1];
endmodule : pao_delay_line

// *** src/pao_output_port.sv ***
/*
  Digital side of a 12-bit pipelined converter: code mapping, clipping, six-stage latency, sleep and output drive.
  Assumes the sampled input arrives as two signed words on clk_sys; enable pins come from outside and are synchronised.
*/
// Notes on behaviour
// RULE1 - Each rising edge takes a new sample
// RULE2 - Word appears six clocks after its sample
// RULE3 - One new word every clock cycle
// RULE4 - Twelve-bit word from positive minus negative input
// RULE5 - Sleep request high means reduced-power state
// RULE6 - Partner supplies clock, 100 kHz to 15 MHz; the constants and the bench use 40 MHz
// RULE7 - Partner never stops clock below 100 ksps
// RULE8 - Partner drives clock near 50 percent duty
// RULE9 - Drive enable high floats data pins
// RULE10 - Pipeline keeps running whatever drive enable does
// RULE11 - Partner avoids sharing bus through drive enable
// RULE12 - Differential table: zero, midscale, full scale
// RULE13 - Single-ended: quarter and three-quarter scale points
// RULE14 - Overrange saturates at min or max code
// RULE15 - Sleep makes outputs undefined, pipeline lost
// RULE16 - Partner trusts word only when both pins low
// RULE17 - Partner waits about 500 ns after sleep
// RULE18 - Partner discards six words after wake
`timescale 1ns/10ps
`include "pao_regs.svh"
module pao_output_port #(
  parameter int WIDTH = `PAO_WORD_W,
  parameter int DEPTH = `PAO_PIPE_DEPTH,
  parameter int RECOVER_CYC = `PAO_RECOVER_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic signed [WIDTH-1:0] vin_pos,
  input wire logic signed [WIDTH-1:0] vin_neg,
  input wire logic sleep_request,
  input wire logic drive_enable_n,
  output logic [WIDTH-1:0] data_out,
  output logic data_oe,
  output logic low_power,
  output logic settling
);
  localparam int CW = $clog2(RECOVER_CYC + 1);
  localparam logic signed [WIDTH+1:0] HALF = (WIDTH+2)'(1 <<< (WIDTH-1));
  localparam logic signed [WIDTH+1:0] TOP = (WIDTH+2)'((1 <<< WIDTH) - 1);

  typedef struct packed {
    logic [1:0] slp_sync;
    logic [1:0] oe_sync;
    logic [WIDTH-1:0] sample;
    pao_pkg::pao_mode_e mode;
    logic [CW-1:0] rec_cnt;
  } pao_st_s;
  pao_st_s st_q;
  pao_st_s st_d;

  logic signed [WIDTH+1:0] diff;
  logic signed [WIDTH+1:0] code;
  logic [WIDTH-1:0] pipe_out;
  logic asleep;

  // Offset-binary mapping with clipping; input LSB equals one output code
  always_comb begin
    diff = (WIDTH+2)'(vin_pos) - (WIDTH+2)'(vin_neg); // see RULE4
    code = diff + HALF; // see RULE12 see RULE13
    if (code < 0) begin
      code = '0; // see RULE14
    end else if (code > TOP) begin
      code = TOP; // see RULE14
    end
  end

  assign asleep = (st_q.mode == pao_pkg::PAO_SLEEP);

  // Sampling, pin synchronisers and sleep sequencing
  always_comb begin
    st_d = st_q;
    st_d.slp_sync = {st_q.slp_sync[0], sleep_request};
    st_d.oe_sync = {st_q.oe_sync[0], drive_enable_n};
    st_d.sample = code[WIDTH-1:0]; // see RULE1 see RULE3
    case (st_q.mode)
      pao_pkg::PAO_RUN: begin
        if (st_q.slp_sync[1]) begin
          st_d.mode = pao_pkg::PAO_SLEEP; // see RULE5
        end
      end
      pao_pkg::PAO_SLEEP: begin
        st_d.sample = '0; // see RULE15
        if (!st_q.slp_sync[1]) begin
          st_d.mode = pao_pkg::PAO_WAKE;
          st_d.rec_cnt = CW'(RECOVER_CYC);
        end
      end
      pao_pkg::PAO_WAKE: begin
        if (st_q.slp_sync[1]) begin
          st_d.mode = pao_pkg::PAO_SLEEP;
        end else if (st_q.rec_cnt == '0) begin
          st_d.mode = pao_pkg::PAO_RUN; // see RULE17
        end else begin
          st_d.rec_cnt = st_q.rec_cnt - CW'(1);
        end
      end
      default: begin
        st_d.mode = pao_pkg::PAO_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= '0;
      st_q.mode <= pao_pkg::PAO_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // Six stages after the sample register: word shows six clocks after capture
  pao_delay_line #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_pipe (
    .clk_sys(clk_sys),
    .reset(reset),
    .flush(asleep), // see RULE15
    .din(st_q.sample),
    .dout(pipe_out)
  );

  // Data pins follow the pipeline regardless of drive enable
  assign data_out = pipe_out; // see RULE2 see RULE10
  assign data_oe = ~st_q.oe_sync[1]; // see RULE9
  assign low_power = asleep;
  assign settling = (st_q.mode == pao_pkg::PAO_WAKE);
endmodule : pao_output_port

// *** sim/pao_port_checker.sv ***
/* Port checks for the converter output port.
   Bound to pao_output_port; sees only its ports. */
`timescale 1ns/10ps
module pao_port_checker #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 6,
  parameter int RECOVER_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic signed [WIDTH-1:0] vin_pos,
  input wire logic signed [WIDTH-1:0] vin_neg,
  input wire logic sleep_request,
  input wire logic drive_enable_n,
  input wire logic [WIDTH-1:0] data_out,
  input wire logic data_oe,
  input wire logic low_power,
  input wire logic settling
);
  int run_q;
  int set_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Awake and settling cycle counts
  always_ff @(posedge clk_sys) begin
    run_q <= (reset || low_power) ? 0 : (run_q > DEPTH ? run_q : run_q + 1);
    set_q <= (reset || !settling) ? 0 : set_q + 1;
  end
  function automatic int code(int p, int n);
    return (p - n < -2048) ? 0 : ((p - n > 2047) ? 4095 : p - n + 2048);
  endfunction : code
  sequence s_full; run_q > DEPTH; endsequence
  sequence s_calm; !$past(reset) && !$past(reset, 2); endsequence
  sequence s_calm3; !$past(reset) && !$past(reset, 2) && !$past(reset, 3); endsequence
  a_word_latency: assert property (s_full |-> data_out == code($past(vin_pos, 7), $past(vin_neg, 7)))
    else $error("word latency");
  a_drive_sync: assert property (s_calm |-> data_oe == !$past(drive_enable_n, 2))
    else $error("drive enable");
  a_sleep_sync: assert property (s_calm3 |-> low_power == $past(sleep_request, 3))
    else $error("sleep entry");
  a_sleep_flush: assert property (low_power && $past(low_power) |-> data_out == '0)
    else $error("sleep flush");
  a_wake_settle: assert property ($fell(low_power) |-> settling)
    else $error("wake settle");
  a_settle_len: assert property ($fell(settling) |-> set_q == RECOVER_CYC + 1)
    else $error("settle length");
  a_settle_max: assert property (settling |-> set_q <= RECOVER_CYC)
    else $error("settle overrun");
  a_power_excl: assert property (low_power |-> !settling)
    else $error("sleep and settle");
endmodule : pao_port_checker
bind pao_output_port pao_port_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH), .RECOVER_CYC(RECOVER_CYC)) chk_u (
  .clk_sys(clk_sys), .reset(reset), .vin_pos(vin_pos), .vin_neg(vin_neg), .sleep_request(sleep_request),
  .drive_enable_n(drive_enable_n), .data_out(data_out), .data_oe(data_oe), .low_power(low_power),
  .settling(settling));

// *** sim/pao_capture_model.sv ***
/* Capture logic on the far side of the port.
   Assumes data settles before the falling clock edge. */
`timescale 1ns/10ps
module pao_capture_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] data_out,
  input wire logic data_oe,
  input wire logic low_power,
  input wire logic settling,
  output logic [11:0] cap_word,
  output logic cap_valid
);
  int skip_q;
  // Latch on falling edge; drop words until refilled
  always_ff @(negedge clk_sys) begin
    if (reset || low_power) begin
      skip_q <= 6;
      cap_valid <= 1'b0;
    end else begin
      skip_q <= (!settling && skip_q > 0) ? skip_q - 1 : skip_q;
      cap_valid <= data_oe && !settling && skip_q == 0;
      cap_word <= data_out;
    end
  end
endmodule : pao_capture_model

// *** sim/pipelined_adc_output_port_bench.sv ***
/* Bench for the converter output port.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
module pipelined_adc_output_port_bench;
  logic clk_sys = 0, reset = 1, sleep_request = 0, drive_enable_n = 0;
  logic signed [11:0] vin_pos = '0, vin_neg = '0;
  logic [11:0] data_out, cap_word;
  logic data_oe, low_power, settling, cap_valid;
  int num_errors = 0, cmp_count = 0;
  logic [35:0] rows [10] = '{36'hc00400000, 36'h000000800, 36'h400c00fff, 36'he00200400, 36'h200e00c00,
    36'hc00000400, 36'h400000c00, 36'h7ff800fff, 36'h8007ff000, 36'h001000801};
  // One converter alone on its data bus
  pao_output_port #(.RECOVER_CYC(2)) dut_u (.clk_sys(clk_sys), .reset(reset), .vin_pos(vin_pos),
    .vin_neg(vin_neg), .sleep_request(sleep_request), .drive_enable_n(drive_enable_n), .data_out(data_out),
    .data_oe(data_oe), .low_power(low_power), .settling(settling));
  pao_capture_model cap_u (.clk_sys(clk_sys), .reset(reset), .data_out(data_out), .data_oe(data_oe),
    .low_power(low_power), .settling(settling), .cap_word(cap_word), .cap_valid(cap_valid));
  // Clock, free running, never stopped
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #5000;
    num_errors++;
    conclude();
  end
  // Tests
  initial begin
    repeat (4) @(posedge clk_sys);
    #2;
    chk("reset word", 12'h000, data_out);
    reset = 0;
    $display("reset test done");
    for (int j = 0; j < 17; j++) begin
      @(posedge clk_sys);
      #2;
      if (j >= 7) chk("word", rows[j - 7][11:0], data_out);
      if (j < 10) {vin_pos, vin_neg} = rows[j][35:12];
      drive_enable_n = (j >= 3 && j < 6);
      if (j == 5) chk("drive", 12'h000, data_oe);
    end
    $display("table test done");
    vin_pos = '0;
    sleep_request = 1;
    repeat (4) @(posedge clk_sys);
    #2;
    chk("sleep", 12'h001, low_power);
    chk("sleep word", 12'h000, data_out);
    sleep_request = 0;
    repeat (3) @(posedge clk_sys);
    #2;
    chk("settling", 12'h001, settling);
    for (int k = 0; k < 40 && cap_valid !== 1'b1; k++) @(posedge clk_sys);
    chk("kept word", 12'h800, cap_word);
    $display("sleep test done");
    conclude();
  end
endmodule : pipelined_adc_output_port_bench
